// ---- common/tlv_pkg.sv ----
// tlv_pkg: shared constants and carriers for the three-level vectored irq block.
// assumes one 40 MHz clock and synchronous active-high reset.
package tlv_pkg;

  localparam int NUM_SRC = 18;
  localparam int NUM_VEC = 10;

  // vector addresses, first at 0x0003, spaced 8 apart
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // source bit positions inside the source vector
  localparam int SRC_EXT_A     = 0;
  localparam int SRC_EXT_B     = 1;
  localparam int SRC_EXT_C     = 2;
  localparam int SRC_TMR0_LO   = 3;
  localparam int SRC_EXT_E     = 4;
  localparam int SRC_EXT_D     = 5;
  localparam int SRC_BASE_TMR  = 6;
  localparam int SRC_TMR0_HI   = 7;
  localparam int SRC_TMR1_LO   = 8;
  localparam int SRC_TMR1_HI   = 9;
  localparam int SRC_SYNC_SER  = 10;
  localparam int SRC_ASYNC_RX  = 11;
  localparam int SRC_ASER      = 12;
  localparam int SRC_ASYNC_TX  = 13;
  localparam int SRC_ADC       = 14;
  localparam int SRC_TMR6      = 15;
  localparam int SRC_TMR7      = 16;
  localparam int SRC_PORT0     = 17;

  // vector index of the pin a and pin b vectors
  localparam int VEC_EXT_A = 0;
  localparam int VEC_EXT_B = 1;

  // level encoding; none means idle, nothing in service
  typedef enum logic [1:0] {
    TLV_LVL_NONE    = 2'b00,
    TLV_LVL_LOW     = 2'b01,
    TLV_LVL_HIGH    = 2'b10,
    TLV_LVL_HIGHEST = 2'b11
  } tlv_level_t;

  typedef enum logic [1:0] {
    TLV_RUN       = 2'b00,
    TLV_HALT      = 2'b01,
    TLV_HOLD      = 2'b10,
    TLV_XTAL_HOLD = 2'b11
  } tlv_mode_t;

  localparam logic [NUM_VEC-1:0] RST_LEVEL_SEL = 10'h000;
  localparam logic [3:0]         RST_DEPTH     = 4'h0;

  // grant carrier towards the core
  typedef struct packed {
    logic             valid;
    logic [3:0]       index;
    logic [15:0]      addr;
    tlv_level_t       level;
  } tlv_grant_t;

endpackage

// ---- logic/tlv_arbiter.sv ----
// tlv_arbiter: picks the winning vector among eligible pending requests.
// assumes pending and per-vector levels are stable inputs; purely combinational.
`timescale 1ns/100ps
module tlv_arbiter (
  input  wire logic [tlv_pkg::NUM_VEC-1:0] req,
  input  wire logic [2*tlv_pkg::NUM_VEC-1:0] lvl,
  output logic                             hit,
  output logic [3:0]                       index,
  output tlv_pkg::tlv_level_t              level
);

  always_comb begin
    hit   = 1'b0;
    index = 4'h0;
    level = tlv_pkg::TLV_LVL_NONE;
    // strictly greater keeps the lowest address on a tie
    for (int i = 0; i < tlv_pkg::NUM_VEC; i++) begin
      if (req[i] && (lvl[2*i +: 2] > level)) begin  // see RULE3 see RULE4
        hit   = 1'b1;
        index = 4'(i);
        level = tlv_pkg::tlv_level_t'(lvl[2*i +: 2]);
      end
    end
  end

endmodule

// ---- logic/tlv_irq_ctrl.sv ----
// tlv_irq_ctrl: three-level vectored interrupt controller with standby wake logic.
// assumes sources are level flags held by peripherals until software clears them,
// and a core that acknowledges grants and signals return-from-interrupt.
//
// Overview of operation
// RULE1: three nesting levels, in-service level tracked
// RULE2: refuse requests at or below in-service level
// RULE3: simultaneous requests: highest level wins
// RULE4: equal level: smallest vector address wins
// RULE5: 18 sources onto 10 vectors, level options
// RULE6: halt released by any accepted interrupt
// RULE7: hold released by pins a,b,c,e, port zero
// RULE8: pins a,b wake only when level-detected
// RULE9: crystal hold also woken by base timer
// RULE10: reset pin or system reset ends standby
// RULE11: refused requests stay pending until accepted
`timescale 1ns/100ps
module tlv_irq_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [tlv_pkg::NUM_SRC-1:0] src_req,
  input  wire logic [tlv_pkg::NUM_SRC-1:0] src_en,
  input  wire logic [tlv_pkg::NUM_VEC-1:0] level_sel,
  input  wire logic                        master_en,
  input  wire logic                        ext_a_level_mode,
  input  wire logic                        ext_b_level_mode,
  input  wire logic                        xtal_selected,
  input  wire tlv_pkg::tlv_mode_t          mode_req,
  input  wire logic                        mode_req_valid,
  input  wire logic                        int_ack,
  input  wire logic                        int_return,
  output tlv_pkg::tlv_grant_t              grant,
  output tlv_pkg::tlv_level_t              in_service_level,
  output tlv_pkg::tlv_mode_t               standby_mode,
  output logic                             wake,
  output logic [tlv_pkg::NUM_VEC-1:0]      pending
);

  localparam int NV = tlv_pkg::NUM_VEC;

  // nesting depth is at most three, one slot per level
  typedef struct packed {
    tlv_pkg::tlv_grant_t grant;
    tlv_pkg::tlv_level_t stack0;
    tlv_pkg::tlv_level_t stack1;
    tlv_pkg::tlv_level_t stack2;
    logic [1:0]          depth;
    tlv_pkg::tlv_mode_t  mode;
    logic                wake;
    logic [NV-1:0]       pending;
  } tlv_state_t;

  tlv_state_t state;
  tlv_state_t next_state;

  localparam int NUM_SRC_W = tlv_pkg::NUM_SRC;
  logic [NUM_SRC_W-1:0] src_live;
  logic [NV-1:0]        vec_req;
  logic [2*NV-1:0]      vec_lvl;
  logic [NV-1:0]        eligible;
  logic                 arb_hit;
  logic [3:0]           arb_index;
  tlv_pkg::tlv_level_t  arb_level;
  logic                 hold_wake;

  // maps a vector's select bit to its level; pin a and b vectors reach highest
  function automatic tlv_pkg::tlv_level_t vec_level(input int v, input logic sel);
    if (!sel)
      vec_level = tlv_pkg::TLV_LVL_LOW;
    else if (v == tlv_pkg::VEC_EXT_A || v == tlv_pkg::VEC_EXT_B)
      vec_level = tlv_pkg::TLV_LVL_HIGHEST;  // see RULE5
    else
      vec_level = tlv_pkg::TLV_LVL_HIGH;  // see RULE5
  endfunction

  function automatic tlv_pkg::tlv_level_t top_level(input tlv_state_t s);
    case (s.depth)
      2'd1:    top_level = s.stack0;
      2'd2:    top_level = s.stack1;
      2'd3:    top_level = s.stack2;
      default: top_level = tlv_pkg::TLV_LVL_NONE;
    endcase
  endfunction

  assign src_live = src_req & src_en;

  // source merge onto vectors
  always_comb begin
    vec_req[0] = src_live[tlv_pkg::SRC_EXT_A];  // see RULE5
    vec_req[1] = src_live[tlv_pkg::SRC_EXT_B];
    vec_req[2] = src_live[tlv_pkg::SRC_EXT_C] | src_live[tlv_pkg::SRC_TMR0_LO]
               | src_live[tlv_pkg::SRC_EXT_E];
    vec_req[3] = src_live[tlv_pkg::SRC_EXT_D] | src_live[tlv_pkg::SRC_BASE_TMR];
    vec_req[4] = src_live[tlv_pkg::SRC_TMR0_HI];
    vec_req[5] = src_live[tlv_pkg::SRC_TMR1_LO] | src_live[tlv_pkg::SRC_TMR1_HI];
    vec_req[6] = src_live[tlv_pkg::SRC_SYNC_SER] | src_live[tlv_pkg::SRC_ASYNC_RX];
    vec_req[7] = src_live[tlv_pkg::SRC_ASER] | src_live[tlv_pkg::SRC_ASYNC_TX];
    vec_req[8] = src_live[tlv_pkg::SRC_ADC] | src_live[tlv_pkg::SRC_TMR6]
               | src_live[tlv_pkg::SRC_TMR7];
    vec_req[9] = src_live[tlv_pkg::SRC_PORT0];
    for (int v = 0; v < NV; v++) begin
      vec_lvl[2*v +: 2] = vec_level(v, level_sel[v]);
    end
  end

  // only strictly higher than in service may nest
  always_comb begin
    for (int v = 0; v < NV; v++) begin
      eligible[v] = vec_req[v] && master_en
                  && (vec_lvl[2*v +: 2] > top_level(state));  // see RULE2
    end
  end

  tlv_arbiter u_arb (
    .req   (eligible),
    .lvl   (vec_lvl),
    .hit   (arb_hit),
    .index (arb_index),
    .level (arb_level)
  );

  // hold wake: edge-mode pins a and b cannot wake, the clock being stopped
  always_comb begin
    hold_wake = (src_req[tlv_pkg::SRC_EXT_A] && ext_a_level_mode)  // see RULE8
             || (src_req[tlv_pkg::SRC_EXT_B] && ext_b_level_mode)  // see RULE8
             || src_req[tlv_pkg::SRC_EXT_C] || src_req[tlv_pkg::SRC_EXT_E]
             || src_req[tlv_pkg::SRC_PORT0];  // see RULE7
  end

  always_comb begin
    next_state = state;
    next_state.wake = 1'b0;
    next_state.pending = vec_req;  // see RULE11
    // grant is re-arbitrated every cycle without ack or return; a new winner may replace it
    if (int_ack && state.grant.valid && state.depth != 2'd3) begin
      case (state.depth)
        2'd0:    next_state.stack0 = state.grant.level;  // see RULE1
        2'd1:    next_state.stack1 = state.grant.level;
        default: next_state.stack2 = state.grant.level;
      endcase
      next_state.depth = state.depth + 2'd1;
      next_state.grant.valid = 1'b0;
    end else if (int_return && state.depth != 2'd0) begin
      next_state.depth = state.depth - 2'd1;  // see RULE1
      next_state.grant.valid = 1'b0;
    end else begin
      next_state.grant.valid = arb_hit;
      next_state.grant.index = arb_index;
      next_state.grant.addr  = tlv_pkg::VEC_BASE
                             + 16'(arb_index) * tlv_pkg::VEC_STEP;  // see RULE4
      next_state.grant.level = arb_level;
    end
    case (state.mode)
      tlv_pkg::TLV_RUN: begin
        if (mode_req_valid)
          next_state.mode = mode_req;
      end
      tlv_pkg::TLV_HALT: begin
        if (arb_hit) begin  // see RULE6
          next_state.mode = tlv_pkg::TLV_RUN;
          next_state.wake = 1'b1;
        end
      end
      tlv_pkg::TLV_HOLD: begin
        if (hold_wake) begin  // see RULE7
          next_state.mode = tlv_pkg::TLV_RUN;
          next_state.wake = 1'b1;
        end
      end
      tlv_pkg::TLV_XTAL_HOLD: begin
        if (hold_wake || (src_req[tlv_pkg::SRC_BASE_TMR] && xtal_selected)) begin  // see RULE9
          next_state.mode = tlv_pkg::TLV_RUN;
          next_state.wake = 1'b1;
        end
      end
      default: next_state.mode = tlv_pkg::TLV_RUN;
    endcase
  end

  // reset covers reset pin, watchdog and low-voltage resets alike
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state        <= '0;  // see RULE10
      state.mode   <= tlv_pkg::TLV_RUN;
      state.depth  <= 2'd0;
    end else begin
      state <= next_state;
    end
  end

  assign grant            = state.grant;
  assign in_service_level = top_level(state);
  assign standby_mode     = state.mode;
  assign wake             = state.wake;
  assign pending          = state.pending;

endmodule

// ---- tb/tlv_irq_ctrl_sva.sv ----
// tlv_irq_sva: port checker for the irq controller.
// assumes one clock domain; bound to every tlv_irq_ctrl.
`timescale 1ns/100ps
module tlv_irq_sva (
  input wire logic                        sys_clk,
  input wire logic                        reset,
  input wire logic [tlv_pkg::NUM_SRC-1:0] src_req,
  input wire logic                        ext_a_level_mode,
  input wire logic                        xtal_selected,
  input wire logic                        int_ack,
  input wire logic                        int_return,
  input wire tlv_pkg::tlv_grant_t         grant,
  input wire tlv_pkg::tlv_level_t         in_service_level,
  input wire tlv_pkg::tlv_mode_t          standby_mode,
  input wire logic                        wake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_clears: assert property (
    int_ack && grant.valid |=> !grant.valid) else $error("grant kept after ack");
  a_level_tracks: assert property (
    int_ack && grant.valid |=> in_service_level == $past(grant.level))
    else $error("level not taken");
  a_level_steady: assert property (
    !int_ack && !int_return |=> $stable(in_service_level)) else $error("level moved");
  a_grant_above: assert property (
    grant.valid |-> grant.level > in_service_level) else $error("grant at or below");
  a_addr_pairs: assert property (
    grant.valid |-> grant.addr == tlv_pkg::VEC_BASE + tlv_pkg::VEC_STEP * grant.index)
    else $error("bad vector address");
  a_wake_pulse: assert property (
    wake |-> standby_mode == tlv_pkg::TLV_RUN ##1 !wake) else $error("bad wake");
  a_hold_port: assert property (
    standby_mode == tlv_pkg::TLV_HOLD && src_req[tlv_pkg::SRC_PORT0]
    |=> standby_mode == tlv_pkg::TLV_RUN && wake) else $error("port0 no wake");
  a_edge_quiet: assert property (
    standby_mode == tlv_pkg::TLV_HOLD && !ext_a_level_mode && src_req == 18'h00001
    |=> standby_mode == tlv_pkg::TLV_HOLD) else $error("edge pin woke");
  a_xtal_base: assert property (
    standby_mode == tlv_pkg::TLV_XTAL_HOLD && xtal_selected
    && src_req[tlv_pkg::SRC_BASE_TMR] |=> wake) else $error("base timer no wake");
  a_reset_run: assert property (disable iff (1'b0)
    reset |=> standby_mode == tlv_pkg::TLV_RUN && !grant.valid && !wake)
    else $error("reset left state");
  c_nest: cover property (in_service_level == tlv_pkg::TLV_LVL_HIGHEST);
  c_xtal: cover property (standby_mode == tlv_pkg::TLV_XTAL_HOLD);
  c_wake: cover property (wake);
endmodule
bind tlv_irq_ctrl tlv_irq_sva u_sva (.sys_clk, .reset, .src_req, .ext_a_level_mode,
  .xtal_selected, .int_ack, .int_return, .grant, .in_service_level, .standby_mode, .wake);

// ---- tb/tlv_core_model.sv ----
// tlv_core_model: core side that takes grants.
// assumes returns are pulsed by the bench.
`timescale 1ns/100ps
module tlv_core_model (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                slow,
  input  wire tlv_pkg::tlv_grant_t grant,
  output logic                     int_ack
);
  logic [1:0] wait_cnt;
  // slow core sits three cycles on a grant first
  always_ff @(posedge sys_clk) begin
    if (reset || !grant.valid || int_ack) begin
      int_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      int_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// ---- tb/tlv_irq_ctrl_tb.sv ----
// tlv_irq_ctrl_tb: scenario bench for the irq controller.
// assumes the core model acks grants; sources and returns come from here.
`timescale 1ns/100ps
module tlv_irq_ctrl_tb;
  logic                sys_clk = 1'b0;
  logic                reset = 1'b1;
  logic [17:0]         src_req = 18'h00000;
  logic [9:0]          level_sel = 10'h000;
  logic                master_en = 1'b1;
  logic                ext_a_level_mode = 1'b0;
  logic                xtal_selected = 1'b0;
  tlv_pkg::tlv_mode_t  mode_req = tlv_pkg::TLV_RUN;
  logic                mode_req_valid = 1'b0;
  logic                int_return = 1'b0;
  logic                slow = 1'b0;
  logic                int_ack;
  tlv_pkg::tlv_grant_t grant;
  tlv_pkg::tlv_level_t in_service_level;
  tlv_pkg::tlv_mode_t  standby_mode;
  logic                wake;
  logic [9:0]          pending;
  int                  n_fail = 0;
  int                  n_checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  tlv_irq_ctrl uut (.sys_clk, .reset, .src_req, .src_en(18'h3FFFF), .level_sel, .master_en,
    .ext_a_level_mode, .ext_b_level_mode(1'b0), .xtal_selected, .mode_req, .mode_req_valid,
    .int_ack, .int_return, .grant, .in_service_level, .standby_mode, .wake, .pending);
  tlv_core_model core (.sys_clk, .reset, .slow, .grant, .int_ack);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // waits for a grant the core is taking
  task automatic take(output tlv_pkg::tlv_grant_t g);
    int i;
    for (i = 0; i < 40 && !(grant.valid === 1'b1 && int_ack === 1'b1); i++) step(1);
    if (i == 40) begin
      n_fail++;
      complete_run;
    end
    g = grant;
    step(1);
  endtask
  task automatic ret;
    int_return = 1'b1;
    step(1);
    int_return = 1'b0;
    step(1);
  endtask
  task automatic s_nest;
    tlv_pkg::tlv_grant_t g;
    level_sel = 10'h010;
    src_req = 18'h20088;
    take(g);
    chk("win idx", 20'h4, g.index);
    chk("win addr", 20'h00023, g.addr);
    chk("isr lvl", tlv_pkg::TLV_LVL_HIGH, in_service_level);
    src_req[tlv_pkg::SRC_TMR0_HI] = 1'b0;
    step(4);
    chk("refused", 20'h0, grant.valid);
    chk("pending", 20'h204, pending);
    level_sel[0] = 1'b1;
    src_req[tlv_pkg::SRC_EXT_A] = 1'b1;
    take(g);
    chk("nest idx", 20'h0, g.index);
    chk("nest lvl", tlv_pkg::TLV_LVL_HIGHEST, in_service_level);
    src_req[tlv_pkg::SRC_EXT_A] = 1'b0;
    ret;
    chk("unwind", tlv_pkg::TLV_LVL_HIGH, in_service_level);
    ret;
    take(g);
    chk("tie idx", 20'h2, g.index);
    src_req[tlv_pkg::SRC_TMR0_LO] = 1'b0;
    ret;
    take(g);
    chk("last addr", 20'h0004B, g.addr);
    src_req[tlv_pkg::SRC_PORT0] = 1'b0;
    ret;
  endtask
  task automatic enter(tlv_pkg::tlv_mode_t m);
    mode_req = m;
    mode_req_valid = 1'b1;
    step(1);
    mode_req_valid = 1'b0;
    step(1);
    chk("mode", m, standby_mode);
  endtask
  task automatic poke(int b, tlv_pkg::tlv_mode_t exp);
    src_req[b] = 1'b1;
    step(1);
    chk("wake pulse", exp == tlv_pkg::TLV_RUN, wake);
    step(2);
    chk("wake mode", exp, standby_mode);
    src_req[b] = 1'b0;
    step(1);
  endtask
  task automatic s_standby;
    slow = 1'b1;
    enter(tlv_pkg::TLV_HALT);
    poke(tlv_pkg::SRC_TMR6, tlv_pkg::TLV_RUN);
    // grants off so hold wakes stand alone
    master_en = 1'b0;
    enter(tlv_pkg::TLV_HOLD);
    poke(tlv_pkg::SRC_EXT_A, tlv_pkg::TLV_HOLD);
    poke(tlv_pkg::SRC_BASE_TMR, tlv_pkg::TLV_HOLD);
    ext_a_level_mode = 1'b1;
    poke(tlv_pkg::SRC_EXT_A, tlv_pkg::TLV_RUN);
    enter(tlv_pkg::TLV_HOLD);
    poke(tlv_pkg::SRC_EXT_C, tlv_pkg::TLV_RUN);
    enter(tlv_pkg::TLV_HOLD);
    poke(tlv_pkg::SRC_EXT_E, tlv_pkg::TLV_RUN);
    enter(tlv_pkg::TLV_HOLD);
    poke(tlv_pkg::SRC_PORT0, tlv_pkg::TLV_RUN);
    xtal_selected = 1'b1;
    enter(tlv_pkg::TLV_XTAL_HOLD);
    poke(tlv_pkg::SRC_BASE_TMR, tlv_pkg::TLV_RUN);
    enter(tlv_pkg::TLV_HOLD);
    reset = 1'b1;
    step(1);
    reset = 1'b0;
    step(1);
    chk("reset mode", tlv_pkg::TLV_RUN, standby_mode);
  endtask
  initial begin
    step(16);
    reset = 1'b0;
    step(1);
    s_nest;
    s_standby;
    complete_run;
  end
endmodule
